// [core/vec_checker.sv]
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "vec_defines.svh"
module vec_checker #(
  parameter int PA_W = 36
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic entry_start,
  input wire logic basic_pass,
  output logic entry_busy,
  output logic entry_done,
  output logic result_zero_flag,
  output logic skip_to_next,
  output logic [7:0] entry_error_code,
  output logic clear_req,
  output logic [63:0] clear_addr,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import vec_pkg::*;

  vec_state_t state_ff;
  vec_state_t nxt_state;

  function automatic logic caps_ok(input logic [31:0] v, input logic [31:0] must1,
                                   input logic [31:0] may1);
    return ((v & must1) == must1) && ((v & ~may1) == 32'h0000_0000);
  endfunction

  function automatic logic addr_ok(input logic [63:0] a, input logic m64);
    if (m64)
    begin
      return (a >> PA_W) == 64'h0;
    end
    return a[63:32] == 32'h0000_0000;
  endfunction

  // arithmetic is carried wider than any physical width
  function automatic logic last_ok(input logic [63:0] base, input logic [31:0] cnt,
                                   input logic m64);
    logic [67:0] last;
    last = {4'h0, base} + {32'h0000_0000, cnt, 4'h0} - 68'h1;
    return (last[67:64] == 4'h0) && addr_ok(last[63:0], m64);
  endfunction

  function automatic logic [63:0] reg64(input logic [`VEC_NREG-1:0][31:0] r,
                                        input logic [5:0] lo);
    return {r[lo + 6'h01], r[lo]};
  endfunction

  logic [31:0] pin;
  logic [31:0] pri;
  logic [31:0] sec_eff;
  logic [31:0] thr;
  logic [31:0] scnt;
  logic [31:0] lcnt;
  logic [63:0] porta;
  logic [63:0] portb;
  logic [63:0] vpage;
  logic [63:0] accp;
  logic [63:0] sbase;
  logic [63:0] lbase;
  logic m64;
  logic acc_virt;
  logic shadow;
  logic vpage_ok;
  logic do_clear;
  logic f_pin, f_pri, f_sec, f_tgt, f_port, f_vpage, f_thr, f_thr_vs;
  logic f_vnmi, f_nwin, f_acc, f_exit, f_store, f_load;
  vec_cause_t first_cause;

  assign pin = state_ff.regs[`VEC_IDX_PIN_CTL];
  assign pri = state_ff.regs[`VEC_IDX_PRI_CTL];
  // secondary controls read as zero while not activated (see R06)
  assign sec_eff = pri[`VEC_PRI_ACT_SEC] ? state_ff.regs[`VEC_IDX_SEC_CTL] : 32'h0000_0000;
  assign thr = state_ff.regs[`VEC_IDX_THRESH];
  assign scnt = state_ff.regs[`VEC_IDX_STORE_CNT];
  assign lcnt = state_ff.regs[`VEC_IDX_LOAD_CNT];
  assign porta = reg64(state_ff.regs, `VEC_IDX_PORTA_LO);
  assign portb = reg64(state_ff.regs, `VEC_IDX_PORTB_LO);
  assign vpage = reg64(state_ff.regs, `VEC_IDX_VPAGE_LO);
  assign accp = reg64(state_ff.regs, `VEC_IDX_ACC_LO);
  assign sbase = reg64(state_ff.regs, `VEC_IDX_STORE_LO);
  assign lbase = reg64(state_ff.regs, `VEC_IDX_LOAD_LO);
  assign m64 = state_ff.regs[`VEC_IDX_CFG][`VEC_CFG_MODE64]; // see R23
  assign acc_virt = sec_eff[`VEC_SEC_ACC_VIRT]; // see R17
  assign shadow = pri[`VEC_PRI_SHADOW];

  assign f_pin = !caps_ok(pin, state_ff.regs[`VEC_IDX_PIN_MUST1],
                          state_ff.regs[`VEC_IDX_PIN_MAY1]); // see R04
  assign f_pri = !caps_ok(pri, state_ff.regs[`VEC_IDX_PRI_MUST1],
                          state_ff.regs[`VEC_IDX_PRI_MAY1]); // see R05
  assign f_sec = pri[`VEC_PRI_ACT_SEC] && !caps_ok(sec_eff, state_ff.regs[`VEC_IDX_SEC_MUST1],
                                                   state_ff.regs[`VEC_IDX_SEC_MAY1]); // see R06
  assign f_tgt = state_ff.regs[`VEC_IDX_TGT_CNT] > `VEC_TGT_MAX; // see R07
  assign f_port = pri[`VEC_PRI_PORT_BM] &&
                  (((porta | portb) & `VEC_PAGE_MASK) != 64'h0 ||
                   !addr_ok(porta, m64) || !addr_ok(portb, m64)); // see R08 see R09
  assign vpage_ok = ((vpage & `VEC_PAGE_MASK) == 64'h0) && addr_ok(vpage, m64);
  assign f_vpage = shadow && !vpage_ok; // see R10
  assign f_thr = shadow && thr[31:4] != 28'h0; // see R13
  assign f_thr_vs = shadow && !acc_virt &&
                    thr[3:0] > state_ff.regs[`VEC_IDX_VPAGE_B80][7:4]; // see R14
  assign f_vnmi = pin[`VEC_PIN_VNMI] && !pin[`VEC_PIN_NMI_EXIT]; // see R15
  assign f_nwin = pri[`VEC_PRI_NMI_WIN] && !pin[`VEC_PIN_VNMI]; // see R16
  assign f_acc = acc_virt && (((accp & `VEC_PAGE_MASK) != 64'h0) || !addr_ok(accp, m64)); // see R17
  assign f_exit = !caps_ok(state_ff.regs[`VEC_IDX_EXIT_CTL], state_ff.regs[`VEC_IDX_EXIT_MUST1],
                           state_ff.regs[`VEC_IDX_EXIT_MAY1]); // see R18
  assign f_store = scnt != 32'h0 && (((sbase & `VEC_LIST_MASK) != 64'h0) ||
                   !addr_ok(sbase, m64) || !last_ok(sbase, scnt, m64)); // see R19 see R20
  assign f_load = lcnt != 32'h0 && (((lbase & `VEC_LIST_MASK) != 64'h0) ||
                  !addr_ok(lbase, m64) || !last_ok(lbase, lcnt, m64)); // see R21 see R22
  // clearing is mandatory with access virtualization, optional by config otherwise
  assign do_clear = shadow && vpage_ok &&
                    (acc_virt || state_ff.regs[`VEC_IDX_CFG][`VEC_CFG_CLR_OPT]); // see R11

  // one cause is reported even when several fail (see R03)
  always_comb
  begin
    first_cause = C_NONE;
    if (f_pin) first_cause = C_PIN;
    else if (f_pri) first_cause = C_PRI;
    else if (f_sec) first_cause = C_SEC;
    else if (f_tgt) first_cause = C_TGT;
    else if (f_port) first_cause = C_PORT;
    else if (f_vpage) first_cause = C_VPAGE;
    else if (f_thr) first_cause = C_THR;
    else if (f_thr_vs) first_cause = C_THR_VS;
    else if (f_vnmi) first_cause = C_VNMI;
    else if (f_nwin) first_cause = C_NWIN;
    else if (f_acc) first_cause = C_ACC;
    else if (f_exit) first_cause = C_EXIT;
    else if (f_store) first_cause = C_STORE;
    else if (f_load) first_cause = C_LOAD;
  end

  always_comb
  begin
    logic [5:0] ridx;
    ridx = s_axi_araddr[7:2];
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    nxt_state.skip = 1'b0;
    nxt_state.clr_req = 1'b0;
    if (s_axi_awvalid && state_ff.awready)
    begin
      nxt_state.aw_got = 1'b1;
      nxt_state.widx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && state_ff.wready)
    begin
      nxt_state.w_got = 1'b1;
      nxt_state.wdata = s_axi_wdata;
      nxt_state.wstrb = s_axi_wstrb;
    end
    if (state_ff.aw_got && state_ff.w_got && !state_ff.bvalid)
    begin
      nxt_state.aw_got = 1'b0;
      nxt_state.w_got = 1'b0;
      nxt_state.bvalid = 1'b1;
      nxt_state.bresp = `VEC_RESP_OKAY;
      if (state_ff.widx < `VEC_IDX_STATUS)
      begin
        for (int b = 0; b < 4; b++)
        begin
          if (state_ff.wstrb[b])
          begin
            nxt_state.regs[state_ff.widx][b*8 +: 8] = state_ff.wdata[b*8 +: 8];
          end
        end
      end
      else if (state_ff.widx != `VEC_IDX_STATUS)
      begin
        nxt_state.bresp = `VEC_RESP_SLVERR;
      end
    end
    if (state_ff.bvalid && s_axi_bready)
    begin
      nxt_state.bvalid = 1'b0;
    end
    nxt_state.awready = !nxt_state.aw_got && !nxt_state.bvalid;
    nxt_state.wready = !nxt_state.w_got && !nxt_state.bvalid;
    if (s_axi_arvalid && state_ff.arready)
    begin
      nxt_state.arready = 1'b0;
      nxt_state.rvalid = 1'b1;
      nxt_state.rresp = `VEC_RESP_OKAY;
      nxt_state.rdata = 32'h0000_0000;
      if (ridx < `VEC_IDX_STATUS)
      begin
        nxt_state.rdata = state_ff.regs[ridx];
      end
      else if (ridx == `VEC_IDX_STATUS)
      begin
        nxt_state.rdata = {11'h000, state_ff.cause, state_ff.err, 5'h00,
                           state_ff.zf, state_ff.fail, state_ff.busy};
      end
      else
      begin
        nxt_state.rresp = `VEC_RESP_SLVERR;
      end
    end
    if (state_ff.rvalid && s_axi_rready)
    begin
      nxt_state.rvalid = 1'b0;
      nxt_state.arready = 1'b1;
    end
    case (state_ff.st)
      ST_IDLE:
      begin
        // a start without basic checks passed is ignored (see R01)
        if (entry_start && basic_pass)
        begin
          nxt_state.st = ST_CHECK;
          nxt_state.busy = 1'b1;
          nxt_state.zf = 1'b0;
        end
      end
      ST_CHECK:
      begin
        nxt_state.st = ST_REPORT;
        nxt_state.cause = first_cause;
        nxt_state.fail = first_cause != C_NONE;
        // clear request goes out before the verdict, pass or fail (see R12)
        nxt_state.clr_req = do_clear; // see R11
        nxt_state.clr_addr = vpage + `VEC_CLR_OFS;
      end
      ST_REPORT:
      begin
        nxt_state.st = ST_IDLE;
        nxt_state.busy = 1'b0;
        nxt_state.done = 1'b1;
        nxt_state.zf = state_ff.fail; // see R02
        nxt_state.skip = state_ff.fail; // see R02
        nxt_state.err = state_ff.fail ? `VEC_ERR_CONTROL : 8'h00; // see R02
      end
      default:
      begin
        nxt_state.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= '0;
      state_ff.regs[`VEC_IDX_CFG] <= `VEC_CFG_RST;
      state_ff.awready <= 1'b1;
      state_ff.wready <= 1'b1;
      state_ff.arready <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign entry_busy = state_ff.busy;
  assign entry_done = state_ff.done;
  assign result_zero_flag = state_ff.zf;
  assign skip_to_next = state_ff.skip;
  assign entry_error_code = state_ff.err;
  assign clear_req = state_ff.clr_req;
  assign clear_addr = state_ff.clr_addr;
  assign s_axi_awready = state_ff.awready;
  assign s_axi_wready = state_ff.wready;
  assign s_axi_bvalid = state_ff.bvalid;
  assign s_axi_bresp = state_ff.bresp;
  assign s_axi_arready = state_ff.arready;
  assign s_axi_rvalid = state_ff.rvalid;
  assign s_axi_rdata = state_ff.rdata;
  assign s_axi_rresp = state_ff.rresp;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_in_check;
    state_ff.st == ST_CHECK;
  endsequence
  sequence s_fail_done;
    ##2 (entry_done && result_zero_flag && skip_to_next && entry_error_code != 8'h00);
  endsequence

  property p_no_start;
    (state_ff.st == ST_IDLE && entry_start && !basic_pass) |=> !entry_busy;
  endproperty
  a_no_start: assert property (p_no_start) else $error("start taken without basic pass"); // see R01

  property p_done_time;
    (state_ff.st == ST_IDLE && entry_start && basic_pass) |=> entry_busy ##2 entry_done;
  endproperty
  a_done_time: assert property (p_done_time) else $error("entry not reported in time"); // see R02

  property p_tgt;
    s_in_check and (state_ff.regs[`VEC_IDX_TGT_CNT] > 32'h4) |-> s_fail_done;
  endproperty
  a_tgt: assert property (p_tgt) else $error("target count over limit passed"); // see R07

  property p_port;
    s_in_check and (pri[`VEC_PRI_PORT_BM] && porta[11:0] != 12'h000) |-> s_fail_done;
  endproperty
  a_port: assert property (p_port) else $error("misaligned port bitmap passed"); // see R08

  property p_thr;
    s_in_check and (shadow && thr[31:4] != 28'h0) |-> s_fail_done;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold high bits passed"); // see R13

  property p_vnmi;
    s_in_check and (pin[`VEC_PIN_VNMI] && !pin[`VEC_PIN_NMI_EXIT]) |-> s_fail_done;
  endproperty
  a_vnmi: assert property (p_vnmi) else $error("virtual nmi without nmi exiting passed"); // see R15

  property p_nwin;
    s_in_check and (pri[`VEC_PRI_NMI_WIN] && !pin[`VEC_PIN_VNMI]) |-> s_fail_done;
  endproperty
  a_nwin: assert property (p_nwin) else $error("nmi window without virtual nmi passed"); // see R16

  property p_store;
    s_in_check and (scnt != 32'h0 && sbase[3:0] != 4'h0) |-> s_fail_done;
  endproperty
  a_store: assert property (p_store) else $error("misaligned store list passed"); // see R19

  property p_clear;
    s_in_check and (shadow && acc_virt && vpage[11:0] == 12'h000 && addr_ok(vpage, m64))
      |=> clear_req && clear_addr == vpage + 64'h81;
  endproperty
  a_clear: assert property (p_clear) else $error("page bytes not cleared"); // see R11

  property p_clear_stays;
    clear_req |=> entry_done;
  endproperty
  a_clear_stays: assert property (p_clear_stays) else $error("clear not followed by verdict"); // see R12

  property p_pin;
    s_in_check and ((pin & ~state_ff.regs[`VEC_IDX_PIN_MAY1]) != 32'h0) |-> s_fail_done;
  endproperty
  a_pin: assert property (p_pin) else $error("pin control outside capability passed"); // see R04

  property p_exit;
    s_in_check and ((state_ff.regs[`VEC_IDX_EXIT_CTL] & ~state_ff.regs[`VEC_IDX_EXIT_MAY1])
      != 32'h0) |-> s_fail_done;
  endproperty
  a_exit: assert property (p_exit) else $error("exit control outside capability passed"); // see R18

  property p_vpage;
    s_in_check and (shadow && vpage[11:0] != 12'h000) |-> s_fail_done;
  endproperty
  a_vpage: assert property (p_vpage) else $error("misaligned priority page passed"); // see R10

  property p_acc;
    s_in_check and (pri[`VEC_PRI_ACT_SEC] && state_ff.regs[`VEC_IDX_SEC_CTL][`VEC_SEC_ACC_VIRT]
      && accp[11:0] != 12'h000) |-> s_fail_done;
  endproperty
  a_acc: assert property (p_acc) else $error("misaligned access page passed"); // see R17

  property p_load;
    s_in_check and (lcnt != 32'h0 && lbase[3:0] != 4'h0) |-> s_fail_done;
  endproperty
  a_load: assert property (p_load) else $error("misaligned load list passed"); // see R21
endmodule // vec_checker

// [core/vec_defines.svh]
// Notes on behaviour
// R01 - control checks start only once the basic entry checks have passed.
// R02 - a failed check aborts entry, skips to next instruction, sets zero flag, records code.
// R03 - checks may run in any order; the code names one cause only.
// R04 - pin controls must match the settings allowed by the pin capability.
// R05 - primary controls must match the settings allowed by the primary capability.
// R06 - secondary controls checked only when activated; otherwise all read as zero.
// R07 - a page-table-base target count above 4 fails the entry.
// R08 - with port bitmaps on, both bitmap addresses need bits 11:0 clear.
// R09 - checked addresses keep within physical width, or below bit 32 without 64-bit.
// R10 - with priority shadow on, the page address needs bits 11:0 clear and width limits.
// R11 - shadow on and checks met: clear bytes 81H-83H when access virtualization is on.
// R12 - that clearing stands even when the entry later fails on another check.
// R13 - with priority shadow on, threshold bits 31:4 must be zero.
// R14 - shadow on, access virtualization off: threshold 3:0 not above byte 80H bits 7:4.
// R15 - virtual nmi set while nmi exiting is clear fails the entry.
// R16 - nmi window exiting set while virtual nmi is clear fails the entry.
// R17 - effective access virtualization needs access page bits 11:0 clear and width limits.
// R18 - exit controls must match the settings allowed by the exit capability.
// R19 - nonzero store count needs store list address low 4 bits clear.
// R20 - store list last byte, base plus count times 16 minus 1, keeps width limits.
// R21 - nonzero load count needs load list low 4 bits clear and width limits.
// R22 - load list last byte, base plus count times 16 minus 1, keeps width limits.
// R23 - physical width is a parameter; a flag picks 64-bit or 32-bit limits.
`ifndef VEC_DEFINES_SVH
`define VEC_DEFINES_SVH
`define VEC_IDX_PIN_CTL 6'h00
`define VEC_IDX_PRI_CTL 6'h01
`define VEC_IDX_SEC_CTL 6'h02
`define VEC_IDX_EXIT_CTL 6'h03
`define VEC_IDX_PIN_MUST1 6'h04
`define VEC_IDX_PIN_MAY1 6'h05
`define VEC_IDX_PRI_MUST1 6'h06
`define VEC_IDX_PRI_MAY1 6'h07
`define VEC_IDX_SEC_MUST1 6'h08
`define VEC_IDX_SEC_MAY1 6'h09
`define VEC_IDX_EXIT_MUST1 6'h0A
`define VEC_IDX_EXIT_MAY1 6'h0B
`define VEC_IDX_TGT_CNT 6'h0C
`define VEC_IDX_THRESH 6'h0D
`define VEC_IDX_PORTA_LO 6'h0E
`define VEC_IDX_PORTA_HI 6'h0F
`define VEC_IDX_PORTB_LO 6'h10
`define VEC_IDX_PORTB_HI 6'h11
`define VEC_IDX_VPAGE_LO 6'h12
`define VEC_IDX_VPAGE_HI 6'h13
`define VEC_IDX_ACC_LO 6'h14
`define VEC_IDX_ACC_HI 6'h15
`define VEC_IDX_STORE_LO 6'h16
`define VEC_IDX_STORE_HI 6'h17
`define VEC_IDX_STORE_CNT 6'h18
`define VEC_IDX_LOAD_LO 6'h19
`define VEC_IDX_LOAD_HI 6'h1A
`define VEC_IDX_LOAD_CNT 6'h1B
`define VEC_IDX_VPAGE_B80 6'h1C
`define VEC_IDX_CFG 6'h1D
`define VEC_IDX_STATUS 6'h1E
`define VEC_NREG 31
`define VEC_PIN_NMI_EXIT 3
`define VEC_PIN_VNMI 5
`define VEC_PRI_SHADOW 21
`define VEC_PRI_NMI_WIN 22
`define VEC_PRI_PORT_BM 25
`define VEC_PRI_ACT_SEC 31
`define VEC_SEC_ACC_VIRT 0
`define VEC_CFG_MODE64 0
`define VEC_CFG_CLR_OPT 1
`define VEC_CFG_RST 32'h0000_0001
`define VEC_REG_RST 32'h0000_0000
`define VEC_TGT_MAX 32'h0000_0004
`define VEC_PAGE_MASK 64'h0000_0000_0000_0FFF
`define VEC_LIST_MASK 64'h0000_0000_0000_000F
`define VEC_CLR_OFS 64'h0000_0000_0000_0081
`define VEC_ERR_CONTROL 8'h01
`define VEC_RESP_OKAY 2'h0
`define VEC_RESP_SLVERR 2'h2
`endif

// [core/vec_pkg.sv]
package vec_pkg;
`include "vec_defines.svh"
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_REPORT} vec_st_t;
  typedef enum logic [4:0] {
    C_NONE, C_PIN, C_PRI, C_SEC, C_TGT, C_PORT, C_VPAGE, C_THR, C_THR_VS,
    C_VNMI, C_NWIN, C_ACC, C_EXIT, C_STORE, C_LOAD
  } vec_cause_t;
  typedef struct packed {
    vec_st_t st;
    logic [`VEC_NREG-1:0][31:0] regs;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [5:0] widx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic busy;
    logic done;
    logic fail;
    logic zf;
    logic skip;
    logic [7:0] err;
    vec_cause_t cause;
    logic clr_req;
    logic [63:0] clr_addr;
  } vec_state_t;
endpackage

// [dv/vec_seq_model.sv]
`timescale 1ns/1ps
module vec_seq_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic pass_in,
  output logic entry_start,
  output logic basic_pass,
  input wire logic entry_done,
  input wire logic skip_to_next,
  input wire logic clear_req,
  input wire logic [63:0] clear_addr,
  output logic got_done,
  output logic got_skip,
  output logic got_clr,
  output logic [63:0] clr_at
);
  // issues one entry request per go pulse and notes what came back
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      entry_start <= 1'b0;
      basic_pass <= 1'b0;
      got_done <= 1'b0;
      got_skip <= 1'b0;
      got_clr <= 1'b0;
      clr_at <= 64'h0;
    end
    else
    begin
      entry_start <= go;
      basic_pass <= go & pass_in;
      if (go)
      begin
        got_done <= 1'b0;
        got_skip <= 1'b0;
        got_clr <= 1'b0;
      end
      if (entry_done)
        got_done <= 1'b1;
      if (entry_done && skip_to_next)
        got_skip <= 1'b1;
      if (clear_req)
      begin
        got_clr <= 1'b1;
        clr_at <= clear_addr;
      end
    end
  end
endmodule // vec_seq_model

// [dv/vec_checker_tb.sv]
`timescale 1ns/1ps
`include "vec_defines.svh"
module vec_checker_tb;
  import vec_pkg::*;
  localparam int PAW = 36;
  localparam logic [63:0] PG = `VEC_PAGE_MASK;
  localparam logic [63:0] LS = `VEC_LIST_MASK;
  localparam logic [31:0] ACT = 32'h8000_0000;
  logic clk, rst_b, go, pass_in, m64, entry_start, basic_pass, done, zf, skip, clr;
  logic got_done, got_skip, got_clr, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, busy;
  logic [7:0] err, awaddr, araddr;
  logic [63:0] caddr, clr_at;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int failures, checks_done;
  vec_checker #(.PA_W(PAW)) u_dut (
    .clk(clk), .rst_b(rst_b), .entry_start(entry_start), .basic_pass(basic_pass),
    .entry_busy(busy), .entry_done(done), .result_zero_flag(zf), .skip_to_next(skip),
    .entry_error_code(err), .clear_req(clr), .clear_addr(caddr),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  vec_seq_model u_seq (
    .clk(clk), .rst_b(rst_b), .go(go), .pass_in(pass_in), .entry_start(entry_start),
    .basic_pass(basic_pass), .entry_done(done), .skip_to_next(skip), .clear_req(clr),
    .clear_addr(caddr), .got_done(got_done), .got_skip(got_skip), .got_clr(got_clr),
    .clr_at(clr_at)
  );
  initial
  begin
    clk = 1'b0;
    forever
      #2 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  function automatic logic wide_bad(input logic [63:0] a, input logic w64);
    if (w64)
      return (a >> PAW) != 64'h0;
    return a[63:32] != 32'h0;
  endfunction
  function automatic logic [63:0] ra(input logic [63:0] lm);
    logic [63:0] a;
    a = {$urandom, $urandom} >> $urandom_range(63, 26);
    if ($urandom_range(1, 0) == 1)
      a = a & ~lm;
    return a;
  endfunction
  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    @(posedge clk);
    awaddr <= {i, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk("bresp", (i > `VEC_IDX_STATUS) ? `VEC_RESP_SLVERR : `VEC_RESP_OKAY, bresp);
  endtask
  task automatic rd(input logic [5:0] i, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic w64(input logic [5:0] i, input logic [63:0] a);
    wr(i, a[31:0]);
    wr(i + 6'h1, a[63:32]);
  endtask
  task automatic run(input logic p, input logic ef, input string nm);
    int n;
    @(posedge clk);
    go <= 1'b1;
    pass_in <= p;
    @(posedge clk);
    go <= 1'b0;
    repeat (2)
      @(posedge clk);
    chk({nm, " busy"}, p, busy);
    n = 0;
    while (!got_done && n < 12)
    begin
      @(posedge clk);
      n++;
    end
    chk({nm, " done"}, p, got_done);
    if (p)
    begin
      chk({nm, " zf"}, ef, zf);
      chk({nm, " skip"}, ef, got_skip);
      chk({nm, " err"}, ef ? `VEC_ERR_CONTROL : 8'h00, err);
    end
    $display("test %s done", nm);
  endtask
  task automatic tpg(input logic [5:0] i, input logic [63:0] a, input string nm);
    w64(i, a);
    run(1'b1, ((a & PG) != 0) || wide_bad(a, m64), nm);
    w64(i, 64'h0);
  endtask
  task automatic tls(input logic [5:0] i, input logic [63:0] a, input logic [31:0] n,
                     input string nm);
    logic [63:0] last;
    last = a + {n, 4'h0} - 64'h1;
    w64(i, a);
    wr(i + 6'h2, n);
    run(1'b1, (n != 0) && (((a & LS) != 0) || wide_bad(a, m64) || wide_bad(last, m64)),
        nm);
    wr(i + 6'h2, 32'h0);
  endtask
  initial
  begin
    repeat (40000)
      @(posedge clk);
    failures++;
    report_and_stop();
  end
  initial
  begin
    logic [31:0] d, b;
    logic [63:0] a, lim;
    logic [1:0] r;
    int k, m;
    {rst_b, go, pass_in, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {awaddr, araddr, wdata} = 48'h0;
    failures = 0;
    checks_done = 0;
    m64 = 1'b1;
    k = $urandom(32'h4189);
    repeat (16)
      @(posedge clk);
    rst_b <= 1'b1;
    rd(`VEC_IDX_CFG, d, r);
    chk("cfg reset", `VEC_CFG_RST, d);
    rd(6'h3F, d, r);
    chk("unmapped resp", `VEC_RESP_SLVERR, r);
    chk("unmapped data", 64'h0, d);
    wr(6'h3F, $urandom);
    wr(`VEC_IDX_STATUS, $urandom);
    rd(`VEC_IDX_STATUS, d, r);
    chk("status", 64'h0, d);
    run(1'b0, 1'b0, "no basic pass");
    run(1'b1, 1'b0, "all clear");
    for (k = 0; k < 4; k++)
    begin
      if (k == 2)
        continue;
      b = 32'h1 << $urandom_range(20, 8);
      wr(6'(k), b);
      run(1'b1, 1'b1, "ctl outside may1");
      wr(6'(5 + 2 * k), b);
      run(1'b1, 1'b0, "ctl inside may1");
      wr(6'(4 + 2 * k), b << 1);
      run(1'b1, 1'b1, "must1 missing");
      wr(6'(4 + 2 * k), 32'h0);
      wr(6'(k), 32'h0);
      wr(6'(5 + 2 * k), 32'hFFFF_FFFF);
    end
    wr(`VEC_IDX_SEC_CTL, $urandom | 32'h1);
    w64(`VEC_IDX_ACC_LO, 64'h1);
    run(1'b1, 1'b0, "sec inactive");
    wr(`VEC_IDX_PRI_CTL, ACT);
    run(1'b1, 1'b1, "sec reserved");
    wr(`VEC_IDX_SEC_MAY1, 32'hFFFF_FFFF);
    run(1'b1, 1'b1, "access page low bits");
    for (k = 0; k < 4; k++)
      tpg(`VEC_IDX_ACC_LO, ra(PG), "access page");
    wr(`VEC_IDX_SEC_CTL, 32'h1);
    for (k = 0; k < 5; k++)
    begin
      b = (k < 3) ? 32'(3 + k) : $urandom_range(15, 0);
      wr(`VEC_IDX_TGT_CNT, b);
      run(1'b1, b > `VEC_TGT_MAX, "target count");
    end
    wr(`VEC_IDX_TGT_CNT, 32'h0);
    wr(`VEC_IDX_PIN_CTL, 32'h1 << `VEC_PIN_VNMI);
    run(1'b1, 1'b1, "vnmi without nmi exit");
    rd(`VEC_IDX_STATUS, d, r);
    chk("fail status", {11'h000, 5'(C_VNMI), `VEC_ERR_CONTROL, 8'h06}, d);
    wr(`VEC_IDX_PIN_CTL, 32'h1 << `VEC_PIN_NMI_EXIT);
    wr(`VEC_IDX_PRI_CTL, ACT | (32'h1 << `VEC_PRI_NMI_WIN));
    run(1'b1, 1'b1, "window without vnmi");
    wr(`VEC_IDX_PIN_CTL, (32'h1 << `VEC_PIN_NMI_EXIT) | (32'h1 << `VEC_PIN_VNMI));
    run(1'b1, 1'b0, "window with vnmi");
    wr(`VEC_IDX_PIN_CTL, 32'h0);
    for (m = 1; m >= 0; m--)
    begin
      m64 = m[0];
      lim = m64 ? (64'h1 << PAW) : (64'h1 << 32);
      wr(`VEC_IDX_CFG, 32'(m));
      wr(`VEC_IDX_PRI_CTL, ACT | (32'h1 << `VEC_PRI_PORT_BM));
      for (k = 0; k < 6; k++)
        tpg(k[0] ? `VEC_IDX_PORTB_LO : `VEC_IDX_PORTA_LO, ra(PG), "port bitmap");
      tpg(`VEC_IDX_PORTA_LO, lim, "port above width");
      tpg(`VEC_IDX_PORTB_LO, lim >> 1, "port top bit");
      for (k = 0; k < 6; k++)
        tls(k[0] ? `VEC_IDX_LOAD_LO : `VEC_IDX_STORE_LO, ra(LS),
            $urandom_range(1, 0) ? $urandom_range(3, 0) : $urandom, "list");
      tls(`VEC_IDX_STORE_LO, lim - 64'h10, 32'h1, "store last fits");
      tls(`VEC_IDX_LOAD_LO, lim - 64'h10, 32'h2, "load last over");
    end
    m64 = 1'b1;
    wr(`VEC_IDX_CFG, `VEC_CFG_RST);
    wr(`VEC_IDX_PRI_CTL, ACT | (32'h1 << `VEC_PRI_SHADOW));
    for (k = 0; k < 5; k++)
    begin
      a = (k == 4) ? 64'h2000 : ra(PG);
      w64(`VEC_IDX_VPAGE_LO, a);
      wr(`VEC_IDX_TGT_CNT, (k == 4) ? 32'h5 : 32'h0);
      run(1'b1, ((a & PG) != 0) || wide_bad(a, 1'b1) || k == 4, "shadow page");
      chk("clear seen", ((a & PG) == 0) && !wide_bad(a, 1'b1), got_clr);
      if (got_clr === 1'b1)
        chk("clear addr", a + `VEC_CLR_OFS, clr_at);
    end
    wr(`VEC_IDX_TGT_CNT, 32'h0);
    wr(`VEC_IDX_SEC_CTL, 32'h0);
    for (k = 0; k < 8; k++)
    begin
      b = (k == 0) ? 32'h10 : $urandom_range(15, 0);
      d = $urandom_range(255, 0);
      wr(`VEC_IDX_THRESH, b);
      wr(`VEC_IDX_VPAGE_B80, d);
      run(1'b1, (b[31:4] != 0) || (b[3:0] > d[7:4]), "threshold");
      chk("no clear", 1'b0, got_clr);
    end
    report_and_stop();
  end
endmodule // vec_checker_tb
